// ==== logic/cpub_consts.svh ====
// constants of the cpu local bus master: codes, reset values, timing
`ifndef CPUB_CONSTS_SVH
`define CPUB_CONSTS_SVH

// cycle type {code_intack, memio, status1_n, status0_n}
`define CPUB_CODE_INTACK   4'h0
`define CPUB_CODE_HALT     4'h4
`define CPUB_CODE_MEMRD    4'h5
`define CPUB_CODE_MEMWR    4'h6
`define CPUB_CODE_IORD     4'h9
`define CPUB_CODE_IOWR     4'ha
`define CPUB_CODE_FETCH    4'hd
`define CPUB_CODE_IDLE     4'hf

// field positions
`define CPUB_ADDR_A1       1
`define CPUB_ADDR_A0       0
`define CPUB_IO_HI_MSB     23
`define CPUB_IO_HI_LSB     16
`define CPUB_LANE_UBE      1
`define CPUB_LANE_A0       0

// reset values
`define CPUB_RST_ADDR      24'h000000
`define CPUB_RST_DATA      16'h0000
`define CPUB_RST_SYNC16    16'h0000

// last system clock of a processor cycle
`define CPUB_PHASE_LAST    1'h1
`define CPUB_PHASE_FIRST   1'h0

`endif

// ==== logic/cpub_pkg.sv ====
// types of the cpu local bus master
package cpub_pkg;

  typedef enum logic [4:0] {
    CPUB_IDLE  = 5'h01,
    CPUB_STAT  = 5'h02,
    CPUB_CMD   = 5'h04,
    CPUB_FLOAT = 5'h08,
    CPUB_GRANT = 5'h10
  } cpub_state_t;

  typedef enum logic [2:0] {
    CPUB_K_INTACK   = 3'h0,
    CPUB_K_MEMRD    = 3'h1,
    CPUB_K_MEMWR    = 3'h2,
    CPUB_K_IORD     = 3'h3,
    CPUB_K_IOWR     = 3'h4,
    CPUB_K_FETCH    = 3'h5,
    CPUB_K_HALT     = 3'h6,
    CPUB_K_SHUTDOWN = 3'h7
  } cpub_kind_t;

  // coded as {upper_byte_enable_n, addr_bit0}
  typedef enum logic [1:0] {
    CPUB_L_WORD  = 2'h0,
    CPUB_L_UPPER = 2'h1,
    CPUB_L_LOWER = 2'h2
  } cpub_lane_t;

  typedef struct packed {
    logic phase;
    logic proc_clk;
  } cpub_div_t;

  typedef struct packed {
    cpub_state_t st;
    logic        req_ready;
    logic        done;
    logic [15:0] rdata;
    logic [23:0] addr;
    logic        ube_n;
    logic        stat1_n;
    logic        stat0_n;
    logic        mio;
    logic        cod;
    logic [15:0] dout;
    logic        bus_oe_n;
    logic        data_oe_n;
    logic        drive;
    logic        ack;
    logic        is_read;
    logic        hold_m;
    logic        hold_s;
    logic        rdy_m;
    logic        rdy_s;
    logic [15:0] din_m;
    logic [15:0] din_s;
  } cpub_master_t;

endpackage

// ==== logic/cpub_clkdiv.sv ====
// divide-by-two processor clock with reset-aligned phase
module cpub_clkdiv
  import cpub_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // processor clock
  output wire logic proc_clk,
  output wire logic phase_end
);
`include "cpub_consts.svh"

  cpub_div_t s;
  cpub_div_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.phase = ~s.phase;
    next_s.proc_clk = s.phase;
  end

  // held at the first phase while reset is low, so release aligns it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s.phase <= `CPUB_PHASE_FIRST;
      s.proc_clk <= 1'b0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign proc_clk = s.proc_clk;
  assign phase_end = (s.phase == `CPUB_PHASE_LAST);

endmodule

// ==== logic/cpub_master.sv ====
// local bus master: cycle status, address, byte lanes, data, bus hold
module cpub_master
  import cpub_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // processor clock
  output wire logic        proc_clk,
  // user request
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_kind,
  input  wire logic [1:0]  req_lanes,
  input  wire logic [23:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output wire logic        req_ready,
  output wire logic        req_done,
  output wire logic [15:0] req_rdata,
  // address and control pins
  output wire logic [23:0] addr_out,
  output wire logic        upper_byte_enable_n,
  output wire logic        cycle_status1_n,
  output wire logic        cycle_status0_n,
  output wire logic        memio_select,
  output wire logic        code_intack_select,
  output wire logic        bus_oe_n,
  // data pins
  input  wire logic [15:0] data_in,
  output wire logic [15:0] data_out,
  output wire logic        data_oe_n,
  // ready and bus hold
  input  wire logic        bus_ready_n,
  input  wire logic        bus_hold_req,
  output wire logic        bus_grant_ack
);
`include "cpub_consts.svh"

  localparam cpub_master_t CPUB_RESET = '{
    st:        CPUB_IDLE,
    req_ready: 1'b0,
    done:      1'b0,
    rdata:     `CPUB_RST_DATA,
    addr:      `CPUB_RST_ADDR,
    ube_n:     1'b1,
    stat1_n:   1'b1,
    stat0_n:   1'b1,
    mio:       1'b1,
    cod:       1'b1,
    dout:      `CPUB_RST_DATA,
    bus_oe_n:  1'b0,
    data_oe_n: 1'b1,
    drive:     1'b0,
    ack:       1'b0,
    is_read:   1'b0,
    hold_m:    1'b0,
    hold_s:    1'b0,
    rdy_m:     1'b1,
    rdy_s:     1'b1,
    din_m:     `CPUB_RST_SYNC16,
    din_s:     `CPUB_RST_SYNC16
  };

  cpub_master_t s;
  cpub_master_t next_s;
  logic         phase_end;
  logic [3:0]   code;

  cpub_clkdiv u_clkdiv (
    .clk       (clk),
    .reset_n   (reset_n),
    .proc_clk  (proc_clk),
    .phase_end (phase_end)
  );

  // {code_intack, memio, status1_n, status0_n}; only legal codes exist
  function automatic logic [3:0] cycle_code(input logic [2:0] kind);
    logic [3:0] c;
    c = `CPUB_CODE_IDLE;
    unique case (kind)
      CPUB_K_INTACK:   c = `CPUB_CODE_INTACK;
      CPUB_K_MEMRD:    c = `CPUB_CODE_MEMRD;
      CPUB_K_MEMWR:    c = `CPUB_CODE_MEMWR;
      CPUB_K_IORD:     c = `CPUB_CODE_IORD;
      CPUB_K_IOWR:     c = `CPUB_CODE_IOWR;
      CPUB_K_FETCH:    c = `CPUB_CODE_FETCH;
      CPUB_K_HALT:     c = `CPUB_CODE_HALT;
      CPUB_K_SHUTDOWN: c = `CPUB_CODE_HALT;
    endcase
    return c;
  endfunction

  function automatic logic is_io(input logic [2:0] kind);
    return (kind == CPUB_K_IORD) || (kind == CPUB_K_IOWR);
  endfunction

  function automatic logic is_rd(input logic [2:0] kind);
    return (kind == CPUB_K_INTACK) || (kind == CPUB_K_MEMRD) ||
           (kind == CPUB_K_IORD) || (kind == CPUB_K_FETCH);
  endfunction

  function automatic logic is_wr(input logic [2:0] kind);
    return (kind == CPUB_K_MEMWR) || (kind == CPUB_K_IOWR);
  endfunction

  always_comb
  begin
    next_s = s;
    code = cycle_code(req_kind);
    next_s.done = 1'b0;
    // pins from outside: two flops before any use
    next_s.hold_m = bus_hold_req;
    next_s.hold_s = s.hold_m;
    next_s.rdy_m = bus_ready_n;
    next_s.rdy_s = s.rdy_m;
    // data synchronised alongside ready so both stay aligned
    next_s.din_m = data_in;
    next_s.din_s = s.din_m;
    unique case (s.st)
      CPUB_IDLE:
      begin
        if (phase_end)
        begin
          // a taken request outranks a hold request arriving with it
          if (s.req_ready && req_valid)
          begin
            next_s.addr = req_addr;
            if (is_io(req_kind))
            begin
              next_s.addr[`CPUB_IO_HI_MSB:`CPUB_IO_HI_LSB] = 8'h00;
            end
            if (req_kind == CPUB_K_HALT)
            begin
              next_s.addr[`CPUB_ADDR_A1] = 1'b1;
            end
            if (req_kind == CPUB_K_SHUTDOWN)
            begin
              next_s.addr[`CPUB_ADDR_A1] = 1'b0;
            end
            // the reserved both-high lane pair falls back to a word
            if (req_lanes == 2'h3)
            begin
              next_s.addr[`CPUB_ADDR_A0] = 1'b0;
              next_s.ube_n = 1'b0;
            end
            else
            begin
              next_s.addr[`CPUB_ADDR_A0] = req_lanes[`CPUB_LANE_A0];
              next_s.ube_n = req_lanes[`CPUB_LANE_UBE];
            end
            next_s.cod = code[3];
            next_s.mio = code[2];
            next_s.stat1_n = code[1];
            next_s.stat0_n = code[0];
            next_s.dout = req_wdata;
            next_s.is_read = is_rd(req_kind);
            next_s.drive = is_wr(req_kind);
            next_s.st = CPUB_STAT;
          end
          else if (s.hold_s)
          begin
            next_s.bus_oe_n = 1'b1;
            next_s.data_oe_n = 1'b1;
            next_s.st = CPUB_FLOAT;
          end
        end
      end
      CPUB_STAT:
      begin
        if (phase_end)
        begin
          next_s.stat1_n = 1'b1;
          next_s.stat0_n = 1'b1;
          next_s.data_oe_n = ~s.drive;
          next_s.st = CPUB_CMD;
        end
      end
      CPUB_CMD:
      begin
        // no wait-state limit: the cycle stretches until ready
        if (phase_end && !s.rdy_s)
        begin
          next_s.done = 1'b1;
          if (s.is_read)
          begin
            next_s.rdata = s.din_s;
          end
          next_s.data_oe_n = 1'b1;
          next_s.st = CPUB_IDLE;
        end
      end
      CPUB_FLOAT:
      begin
        // drivers already off for a whole processor cycle
        if (phase_end)
        begin
          next_s.ack = 1'b1;
          next_s.st = CPUB_GRANT;
        end
      end
      CPUB_GRANT:
      begin
        // ready is not looked at here, so it is ignored while held
        if (phase_end && !s.hold_s)
        begin
          next_s.ack = 1'b0;
          next_s.bus_oe_n = 1'b0;
          next_s.st = CPUB_IDLE;
        end
      end
    endcase
    // ready is offered only in the last clock of an idle cycle
    next_s.req_ready = (next_s.st == CPUB_IDLE) && !phase_end &&
                       !s.hold_s;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      s <= CPUB_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign req_ready           = s.req_ready;
  assign req_done            = s.done;
  assign req_rdata           = s.rdata;
  assign addr_out            = s.addr;
  assign upper_byte_enable_n = s.ube_n;
  assign cycle_status1_n     = s.stat1_n;
  assign cycle_status0_n     = s.stat0_n;
  assign memio_select        = s.mio;
  assign code_intack_select  = s.cod;
  assign bus_oe_n            = s.bus_oe_n;
  assign data_out            = s.dout;
  assign data_oe_n           = s.data_oe_n;
  assign bus_grant_ack       = s.ack;

endmodule

// ==== testbench/cpub_checker.sv ====
// pin-level assertions on the cpu local bus master
module cpub_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // bus pins
  input wire logic        proc_clk,
  input wire logic        req_done,
  input wire logic [23:0] addr_out,
  input wire logic        upper_byte_enable_n,
  input wire logic        cycle_status1_n,
  input wire logic        cycle_status0_n,
  input wire logic        memio_select,
  input wire logic        code_intack_select,
  input wire logic        bus_oe_n,
  input wire logic        data_oe_n,
  input wire logic        bus_ready_n,
  input wire logic        bus_hold_req,
  input wire logic        bus_grant_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire       idle = cycle_status1_n & cycle_status0_n;
  wire [3:0] code = {code_intack_select, memio_select, ~idle, ~idle}
                  & {2'h3, cycle_status1_n, cycle_status0_n};
  logic      wr;
  // direction shown by the last status state
  always_ff @(posedge clk)
    if (!idle)
      wr <= cycle_status1_n & !cycle_status0_n;
  sequence s_one_pcyc;
    !idle ##1 idle;
  endsequence
  a_pclk_halves:
    assert property ($past(reset_n, 3) |-> proc_clk != $past(proc_clk))
    else $error("processor clock not halved");
  a_status_len:
    assert property ($fell(idle) |=> s_one_pcyc)
    else $error("status state not one processor cycle");
  a_no_reserved:
    assert property (!idle |-> code inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h9,
      4'ha, 4'hd} && {upper_byte_enable_n, addr_out[0]} != 2'h3)
    else $error("reserved code or lane emitted");
  a_io_upper:
    assert property (!idle && !memio_select && code_intack_select
      |-> addr_out[23:16] == 8'h00) else $error("io address high not zero");
  a_hold_float:
    assert property (bus_grant_ack |-> bus_oe_n && data_oe_n)
    else $error("bus driven while granted");
  a_float_first:
    assert property ($rose(bus_grant_ack) |-> $past(bus_oe_n, 2))
    else $error("grant before bus floated");
  a_grant_drop:
    assert property (bus_grant_ack && $fell(bus_hold_req)
      |-> ##[1:6] !bus_grant_ack) else $error("grant not dropped");
  a_ready_ends:
    assert property (req_done |-> !$past(bus_ready_n, 3))
    else $error("cycle ended without ready");
  a_write_dir:
    assert property (!data_oe_n |-> wr && !bus_oe_n)
    else $error("data driven outside a write");
endmodule
bind cpub_master cpub_checker chk_u (.*);

// ==== testbench/cpub_mem_model.sv ====
// memory and io devices on the far side, with programmable wait
module cpub_mem_model (
  // clock
  input  wire logic        clk,
  // bus pins
  input  wire logic [23:0] addr_out,
  input  wire logic        upper_byte_enable_n,
  input  wire logic        cycle_status1_n,
  input  wire logic        cycle_status0_n,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe_n,
  // wait states and answers
  input  wire logic [3:0]  wait_cnt,
  output logic             bus_ready_n,
  output wire logic [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [3:0]  a = 4'h0;
  logic [3:0]  c = 4'h0;
  logic        ub_n = 1'b1, a0 = 1'b1, rd = 1'b0, prev = 1'b0;
  wire         st = !(cycle_status1_n & cycle_status0_n);
  // undriven bus never keeps its last value
  assign data_in = !data_oe_n ? data_out : rd ? mem[a] : ~last;
  initial
  begin
    bus_ready_n = 1'b0;
    for (int i = 0; i < 16; i++)
      mem[i] = {12'hc00, 4'(i)};
  end
  always @(posedge clk)
  begin
    prev <= st;
    last <= data_in;
    if (st && !prev)
    begin
      a           <= addr_out[4:1];
      ub_n        <= upper_byte_enable_n;
      a0          <= addr_out[0];
      rd          <= !cycle_status1_n;
      c           <= wait_cnt;
      bus_ready_n <= wait_cnt != 4'h0;
    end
    else if (c != 4'h0)
    begin
      c           <= c - 4'h1;
      bus_ready_n <= c != 4'h1;
    end
    if (!data_oe_n && !ub_n)
      mem[a][15:8] <= data_out[15:8];
    if (!data_oe_n && !a0)
      mem[a][7:0] <= data_out[7:0];
  end
endmodule

// ==== testbench/cpub_master_tb.sv ====
// self-checking bench of the cpu local bus master
module cpub_master_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clk = 0, reset_n = 0, req_valid = 0, bus_hold_req = 0;
  logic [2:0]       req_kind = 3'h0;
  logic [1:0]       req_lanes = 2'h0;
  logic [23:0]      req_addr = 24'h000000;
  logic [15:0]      req_wdata = 16'h0000;
  logic [3:0]       wait_cnt = 4'h0;
  wire logic        req_ready, req_done, proc_clk, upper_byte_enable_n;
  wire logic        cycle_status1_n, cycle_status0_n, memio_select;
  wire logic        code_intack_select, bus_oe_n, data_oe_n, bus_ready_n;
  wire logic        bus_grant_ack;
  wire logic [15:0] req_rdata, data_in, data_out;
  wire logic [23:0] addr_out;
  int               fails = 0, n_checks = 0;
  logic [3:0]       ecode [8] = '{4'h0, 4'h5, 4'h6, 4'h9, 4'ha, 4'hd,
                                  4'h4, 4'h4};
  cpub_master    dut_u (.*);
  cpub_mem_model mem_u (.*);
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_reset;
    logic pc;
    reset_n <= 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(req_ready, 1'b0);
    pc = proc_clk;
    @(posedge clk);
    chk(req_ready, 1'b1);
    chk(proc_clk, !pc);
  endtask
  // one bus cycle; ready wait w, expected address ea, read data er
  task automatic op(input logic [2:0] k, input logic [1:0] ln,
    input logic [23:0] ad, input logic [15:0] wd, input logic [3:0] w,
    input logic [23:0] ea, input logic [15:0] er);
    int n;
    req_valid <= 1'b1;
    req_kind  <= k;
    req_lanes <= ln;
    req_addr  <= ad;
    req_wdata <= wd;
    wait_cnt  <= w;
    n = 0;
    do @(posedge clk); while (!req_ready && ++n < 50);
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (n == 1)
      begin
        chk({code_intack_select, memio_select, cycle_status1_n,
             cycle_status0_n}, ecode[k]);
        chk(addr_out, ea);
        chk({upper_byte_enable_n, addr_out[0]}, ln == 2'h3 ? 2'h0 : ln);
      end
      if (n == 3)
      begin
        chk(data_oe_n, !(k == 3'h2 || k == 3'h4));
        chk(cycle_status1_n & cycle_status0_n, 1'b1);
        if (!data_oe_n)
          chk(data_out, wd);
      end
    end while (!req_done && n < 60);
    chk(24'(n), 24'(5 + 2 * ((w + 1) / 2)));
    if (k inside {3'h0, 3'h1, 3'h3, 3'h5})
      chk(req_rdata, er);
  endtask
  task automatic t_ops;
    op(3'h2, 2'h0, 24'h000010, 16'h1234, 4'h0, 24'h000010, 16'h0);
    op(3'h1, 2'h0, 24'h000010, 16'h0, 4'h3, 24'h000010, 16'h1234);
    op(3'h4, 2'h1, 24'hab0021, 16'hab00, 4'h1, 24'h000021, 16'h0);
    op(3'h3, 2'h2, 24'hff0040, 16'h0, 4'h2, 24'h000040, 16'hab00);
    op(3'h5, 2'h0, 24'h123456, 16'h0, 4'h0, 24'h123456, 16'hc00b);
    op(3'h0, 2'h0, 24'h000008, 16'h0, 4'h0, 24'h000008, 16'hc004);
    op(3'h6, 2'h0, 24'h000000, 16'h0, 4'h0, 24'h000002, 16'h0);
    op(3'h7, 2'h0, 24'h000002, 16'h0, 4'h0, 24'h000000, 16'h0);
    // the reserved lane pair must reach the pins as a word transfer
    op(3'h2, 2'h3, 24'h000031, 16'h5a5a, 4'h0, 24'h000030, 16'h0);
    op(3'h1, 2'h3, 24'h000011, 16'h0, 4'h0, 24'h000010, 16'h5a5a);
  endtask
  task automatic t_hold;
    int n;
    bus_hold_req <= 1'b1;
    n = 0;
    do @(posedge clk); while (!bus_grant_ack && ++n < 20);
    chk(bus_grant_ack, 1'b1);
    chk({bus_oe_n, data_oe_n}, 2'h3);
    // a request while granted must stay pending
    req_valid <= 1'b1;
    repeat (4) @(posedge clk) chk(req_ready, 1'b0);
    req_valid    <= 1'b0;
    bus_hold_req <= 1'b0;
    n = 0;
    do @(posedge clk); while (bus_grant_ack && ++n < 20);
    chk(bus_grant_ack, 1'b0);
    chk(bus_oe_n, 1'b0);
  endtask
  initial
  begin
    #100us;
    fails++;
    results();
  end
  initial
  begin
    t_reset();
    t_ops();
    t_hold();
    t_reset();
    results();
  end
endmodule
